// >>> rtl/dgc_gain_shaper.v
// Gain shaping controls of the dynamics unit: control registers, static
// curve, gain limits and timed release of the applied gain.
// Assumes one control port on clk_sys and levels from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
`include "dgc_gain_map.vh"

module dgc_gain_shaper
#(
  // Cycles per 0.75 dB release step at code zero; benches may shorten it.
  parameter [31:0] REL_STEP_CYCLES =
    `DGC_REL_BASE_PS / `DGC_CLK_PERIOD_PS / `DGC_STEPS_PER_6DB
)
(
  // Clock and reset
  input  wire               clk_sys,
  input  wire               rst,
  // Control port
  input  wire        [15:0] regAddr,
  input  wire        [15:0] regWrData,
  input  wire               regWrEn,
  input  wire               regRdEn,
  output reg         [15:0] regRdData_q,
  output reg                regRdValid_q,
  // Detector inputs
  input  wire               sampleStrobe,
  input  wire        [6:0]  levelIn,
  input  wire        [7:0]  crestIn,
  // Gain output
  output reg  signed [7:0]  gainOut_q,
  output reg                gateActive_q,
  output reg                fastRelease_q
);

  reg         gateEnable_q;
  reg  [3:0]  relRate_q;
  reg  [2:0]  lowLimit_q;
  reg  [1:0]  upLimit_q;
  reg  [15:0] slopes_q;
  reg  [10:0] knees_q;
  reg  [6:0]  level_q;
  reg  [7:0]  crest_q;
  reg  [31:0] relCnt_q;
  reg  [31:0] relLimit;
  reg  signed [7:0]  target;
  reg  signed [11:0] floorGain;
  reg  signed [11:0] ceilGain;
  wire signed [11:0] curveGain;
  wire        gateHit;
  wire        fastHit;
  wire [15:0] limitsWord;

  assign limitsWord = {7'h00, relRate_q, lowLimit_q, upLimit_q};

  // Lower limit code to 0.75 dB units.
  function signed [11:0] lowLimitGain;
    input [2:0] code;
    begin
      case (code)
        3'h0:    lowLimitGain = 12'sd0;
        3'h1:    lowLimitGain = -12'sd16;
        3'h2:    lowLimitGain = -12'sd24;
        3'h3:    lowLimitGain = -12'sd32;
        default: lowLimitGain = -12'sd48;
      endcase
    end
  endfunction

  // Upper limit code to 0.75 dB units.
  function signed [11:0] upLimitGain;
    input [1:0] code;
    begin
      case (code)
        2'h0:    upLimitGain = 12'sd16;
        2'h1:    upLimitGain = 12'sd24;
        2'h2:    upLimitGain = 12'sd32;
        default: upLimitGain = 12'sd48;
      endcase
    end
  endfunction

  // Holds a 4-bit code at its largest legal value; reserved codes above it
  // behave like the largest one.
  function [3:0] clip4;
    input [3:0] code;
    input [3:0] maxCode;
    begin
      if (code > maxCode)
        clip4 = maxCode;
      else
        clip4 = code;
    end
  endfunction

  // Gate floor code to 0.75 dB units: -48 plus 8 per code.
  function signed [11:0] gateFloorGain;
    input [3:0] code;
    begin
      gateFloorGain = $signed({5'h00, clip4(code, `DGC_FLOOR_MAX), 3'h0}) - 12'sd48;
    end
  endfunction

  // Clamps the curve gain between floor and ceiling at full width, so a
  // negative floor is never mistaken for a large positive value.
  function signed [7:0] clampGain;
    input signed [11:0] value;
    input signed [11:0] lowest;
    input signed [11:0] highest;
    reg   signed [11:0] held;
    begin
      if (value < lowest)
        held = lowest;
      else
        held = value;
      if (held > highest)
        held = highest;
      clampGain = held[7:0];
    end
  endfunction

  // Cycles per 0.75 dB release step: the normal rate doubles per code,
  // the fast rate is half, one or four base steps.
  function [31:0] releaseLimit;
    input       fast;
    input [1:0] fastCode;
    input [3:0] rateCode;
    begin
      // fast release half, one or four base steps
      if (fast)
      begin
        case (fastCode)
          2'h0:    releaseLimit = REL_STEP_CYCLES >> 1;
          2'h2:    releaseLimit = REL_STEP_CYCLES << 2;
          default: releaseLimit = REL_STEP_CYCLES;
        endcase
      end
      else
        releaseLimit = REL_STEP_CYCLES << clip4(rateCode, `DGC_REL_MAX);
    end
  endfunction

  // Read value of one register word; unmapped offsets and unbuilt bits
  // read zero.
  function [15:0] readWord;
    input [15:0] addr;
    begin
      case (addr)
        `DGC_ADDR_GATE_CTRL:    readWord = {7'h00, gateEnable_q, 8'h00};
        `DGC_ADDR_LIMITS_DECAY: readWord = limitsWord & `DGC_MASK_LIMITS;
        `DGC_ADDR_GATE_SLOPES:  readWord = slopes_q;
        `DGC_ADDR_KNEE_LEVELS:  readWord = {5'h00, knees_q} & `DGC_MASK_KNEE;
        default:                readWord = 16'h0000;
      endcase
    end
  endfunction

  dgc_gain_curve u_curve
  (
    .levelIn    (level_q),
    .kneeIn     (knees_q[`DGC_KIN_MSB:`DGC_KIN_LSB]),
    .kneeOut    (knees_q[`DGC_KOUT_MSB:`DGC_KOUT_LSB]),
    .hiSlope    (slopes_q[`DGC_HICMP_MSB:`DGC_HICMP_LSB]),
    .loSlope    (slopes_q[`DGC_LOCMP_MSB:`DGC_LOCMP_LSB]),
    .gateEnable (gateEnable_q),
    .gateExp    (slopes_q[`DGC_EXP_MSB:`DGC_EXP_LSB]),
    .curveGain  (curveGain),
    .gateActive (gateHit)
  );

  // crest threshold 16 plus 8 per code
  assign fastHit = crest_q >= ({6'h00, slopes_q[`DGC_QTHR_MSB:`DGC_QTHR_LSB]} * 8'h08
                               + 8'h10);

  // Control register writes; each register holds only its own fields.
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      gateEnable_q <= `DGC_GATE_ENA_RST;
      relRate_q    <= `DGC_REL_RST;
      lowLimit_q   <= `DGC_LOWLIM_RST;
      upLimit_q    <= `DGC_UPLIM_RST;
      slopes_q     <= `DGC_SLOPES_RST;
      knees_q      <= `DGC_KNEE_RST;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        `DGC_ADDR_GATE_CTRL:
          gateEnable_q <= regWrData[`DGC_GATE_ENA_BIT];
        `DGC_ADDR_LIMITS_DECAY:
        begin
          relRate_q  <= regWrData[`DGC_REL_MSB:`DGC_REL_LSB];
          lowLimit_q <= regWrData[`DGC_LOWLIM_MSB:`DGC_LOWLIM_LSB];
          upLimit_q  <= regWrData[`DGC_UPLIM_MSB:`DGC_UPLIM_LSB];
        end
        `DGC_ADDR_GATE_SLOPES:
          slopes_q <= regWrData;
        `DGC_ADDR_KNEE_LEVELS:
          knees_q <= regWrData[`DGC_KIN_MSB:0];
        default:
          gateEnable_q <= gateEnable_q;
      endcase
    end
  end

  // Register reads answer one cycle later; unmapped offsets read zero.
  // A read in the same cycle as a write returns the old value.
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      regRdData_q  <= 16'h0000;
      regRdValid_q <= 1'b0;
    end
    else
    begin
      regRdValid_q <= regRdEn;
      if (regRdEn)
        regRdData_q <= readWord(regAddr);
    end
  end

  // Limits and release step length, combinational.
  always @*
  begin
    // gate floor replaces the lower limit
    if (gateHit)
      floorGain = gateFloorGain(slopes_q[`DGC_FLOOR_MSB:`DGC_FLOOR_LSB]);
    else
      floorGain = lowLimitGain(lowLimit_q);
    ceilGain = upLimitGain(upLimit_q);
    target = clampGain(curveGain, floorGain, ceilGain);
    relLimit = releaseLimit(fastHit, slopes_q[`DGC_QREL_MSB:`DGC_QREL_LSB], relRate_q);
  end

  // Gain tracking: drops at once, recovers one 0.75 dB step per release step.
  // The step counter restarts on every drop, so a rise always waits a whole
  // step after the last attenuation.
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      level_q       <= 7'h00;
      crest_q       <= 8'h00;
      relCnt_q      <= 32'h0000_0000;
      gainOut_q     <= 8'sd0;
      gateActive_q  <= 1'b0;
      fastRelease_q <= 1'b0;
    end
    else
    begin
      if (sampleStrobe)
      begin
        level_q <= levelIn;
        crest_q <= crestIn;
      end
      gateActive_q  <= gateHit;
      fastRelease_q <= fastHit;
      if (target <= gainOut_q)
      begin
        gainOut_q <= target;
        relCnt_q  <= 32'h0000_0000;
      end
      else if (relCnt_q + 32'h0000_0001 >= relLimit)
      begin
        gainOut_q <= gainOut_q + 8'sd1;
        relCnt_q  <= 32'h0000_0000;
      end
      else
        relCnt_q <= relCnt_q + 32'h0000_0001;
    end
  end

endmodule // dgc_gain_shaper
`default_nettype wire

// >>> include/dgc_gain_map.vh
// Register offsets, field positions, reset values and timing counts for
// the dynamics unit gain shaping controls.
// Assumes the includer sets up its own timescale and net type.
`ifndef DGC_GAIN_MAP_VH
`define DGC_GAIN_MAP_VH

// Register word offsets on the control port.
`define DGC_ADDR_GATE_CTRL     16'h0e80
`define DGC_ADDR_LIMITS_DECAY  16'h0e81
`define DGC_ADDR_GATE_SLOPES   16'h0e82
`define DGC_ADDR_KNEE_LEVELS   16'h0e83

// Gate control register.
`define DGC_GATE_ENA_BIT       8

// Gain limits and decay register.
`define DGC_REL_MSB            8
`define DGC_REL_LSB            5
`define DGC_LOWLIM_MSB         4
`define DGC_LOWLIM_LSB         2
`define DGC_UPLIM_MSB          1
`define DGC_UPLIM_LSB          0

// Noise gate and slopes register.
`define DGC_FLOOR_MSB          15
`define DGC_FLOOR_LSB          12
`define DGC_EXP_MSB            11
`define DGC_EXP_LSB            10
`define DGC_QTHR_MSB           9
`define DGC_QTHR_LSB           8
`define DGC_QREL_MSB           7
`define DGC_QREL_LSB           6
`define DGC_HICMP_MSB          5
`define DGC_HICMP_LSB          3
`define DGC_LOCMP_MSB          2
`define DGC_LOCMP_LSB          0

// Knee levels register.
`define DGC_KIN_MSB            10
`define DGC_KIN_LSB            5
`define DGC_KOUT_MSB           4
`define DGC_KOUT_LSB           0

// Reset values.
`define DGC_GATE_ENA_RST       1'h0
`define DGC_REL_RST            4'h9
`define DGC_LOWLIM_RST         3'h4
`define DGC_UPLIM_RST          2'h3
`define DGC_SLOPES_RST         16'h0018
`define DGC_KNEE_RST           11'h000

// Writable bit masks per register.
`define DGC_MASK_LIMITS        16'h01ff
`define DGC_MASK_KNEE          16'h07ff

// Largest legal codes.
`define DGC_REL_MAX            4'hb
`define DGC_LOWLIM_MAX         3'h4
`define DGC_FLOOR_MAX          4'hc
`define DGC_HICMP_MAX          3'h5
`define DGC_LOCMP_MAX          3'h4
`define DGC_KIN_MAX            6'h3c
`define DGC_KOUT_MAX           5'h1e

// Timing: release time at code zero is 1.45 ms per 6 dB (eight 0.75 dB steps).
`define DGC_REL_BASE_PS        1450000000
`define DGC_CLK_PERIOD_PS      8000
`define DGC_STEPS_PER_6DB      8

// Gate threshold in 0.75 dB units below full scale.
`define DGC_GATE_THR           7'h30

`endif

// >>> rtl/dgc_gain_curve.v
// Static gain curve: knee, upper and lower compressor slopes and the noise
// gate expansion, all in 0.75 dB units.
// Assumes level and settings come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "dgc_gain_map.vh"

module dgc_gain_curve
(
  // Level and settings
  input  wire        [6:0]  levelIn,
  input  wire        [5:0]  kneeIn,
  input  wire        [4:0]  kneeOut,
  input  wire        [2:0]  hiSlope,
  input  wire        [2:0]  loSlope,
  input  wire               gateEnable,
  input  wire        [1:0]  gateExp,
  // Result
  output reg  signed [11:0] curveGain,
  output reg                gateActive
);

  reg  [5:0] kneeInUse;
  reg  [4:0] kneeOutUse;
  reg  [7:0] diff;
  reg  [7:0] shaped;
  reg  [7:0] over;
  reg [10:0] extra;

  // Shifts the distance from the knee by the slope code; zero slope and
  // reserved codes give a flat output.
  function [7:0] applySlope;
    input [7:0] d;
    input [2:0] code;
    input [2:0] zeroCode;
    begin
      if (code >= zeroCode)
        applySlope = 8'h00;
      else
        applySlope = d >> code;
    end
  endfunction

  always @*
  begin
    kneeInUse  = (kneeIn > `DGC_KIN_MAX) ? `DGC_KIN_MAX : kneeIn;
    kneeOutUse = (kneeOut > `DGC_KOUT_MAX) ? `DGC_KOUT_MAX : kneeOut;
    diff       = 8'h00;
    shaped     = 8'h00;
    over       = 8'h00;
    extra      = 11'h000;
    if ({1'b0, levelIn} < {2'b00, kneeInUse})
    begin
      diff      = {2'b00, kneeInUse} - {1'b0, levelIn};
      shaped    = applySlope(diff, hiSlope, `DGC_HICMP_MAX);
      curveGain = $signed({5'h00, levelIn}) - $signed({7'h00, kneeOutUse})
                  + $signed({4'h0, shaped});
    end
    else
    begin
      diff      = {1'b0, levelIn} - {2'b00, kneeInUse};
      shaped    = applySlope(diff, loSlope, `DGC_LOCMP_MAX);
      curveGain = $signed({5'h00, levelIn}) - $signed({7'h00, kneeOutUse})
                  - $signed({4'h0, shaped});
    end
    gateActive = gateEnable && (levelIn > `DGC_GATE_THR);
    if (gateActive)
    begin
      // expansion ratio 1, 2, 4 or 8
      over      = {1'b0, levelIn} - {1'b0, `DGC_GATE_THR};
      extra     = {3'h0, over} * ((11'h001 << gateExp) - 11'h001);
      curveGain = curveGain - $signed({1'b0, extra});
    end
  end

endmodule // dgc_gain_curve
`default_nettype wire

// >>> verif/dgc_gain_shaper_assertions.sv
// Port checker for the gain shaper, bound to every instance.
// Assumes the top module's port names and clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module dgc_gain_shaper_chk
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // Control port
  input wire logic        [15:0] regAddr,
  input wire logic               regRdEn,
  input wire logic        [15:0] regRdData_q,
  input wire logic               regRdValid_q,
  // Detector and gain
  input wire logic               sampleStrobe,
  input wire logic        [6:0]  levelIn,
  input wire logic        [7:0]  crestIn,
  input wire logic signed [7:0]  gainOut_q,
  input wire logic               gateActive_q,
  input wire logic               fastRelease_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_RD_ACK: assert property (regRdEn |=> regRdValid_q)
    else $error("read strobe not answered");
  AST_RD_ONLY: assert property (regRdValid_q |-> $past(regRdEn))
    else $error("read valid without strobe");
  AST_RD_HOLD: assert property (!regRdValid_q |-> $stable(regRdData_q))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (regRdEn && regAddr[15:2] != 14'h03a0
    |=> regRdData_q == 16'h0000) else $error("unmapped read not zero");
  AST_GATE_BITS: assert property (regRdEn && regAddr == 16'h0e80
    |=> (regRdData_q & 16'hfeff) == 16'h0000) else $error("gate register spare bits");
  AST_GAIN_RANGE: assert property (gainOut_q >= -8'sd48 && gainOut_q <= 8'sd48)
    else $error("gain outside limits");
  AST_FAST_LOW: assert property (sampleStrobe && crestIn < 8'h10 ##1 !sampleStrobe
    |=> !fastRelease_q) else $error("fast release below threshold");
  AST_GATE_LOUD: assert property (sampleStrobe && levelIn <= 7'h30 ##1 !sampleStrobe
    |=> !gateActive_q) else $error("gate engaged on loud level");
endmodule // dgc_gain_shaper_chk
bind dgc_gain_shaper dgc_gain_shaper_chk chk_u (.clk_sys(clk_sys), .rst(rst),
  .regAddr(regAddr), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
  .regRdValid_q(regRdValid_q), .sampleStrobe(sampleStrobe), .levelIn(levelIn),
  .crestIn(crestIn), .gainOut_q(gainOut_q), .gateActive_q(gateActive_q),
  .fastRelease_q(fastRelease_q));
`default_nettype wire

// >>> verif/dgc_gain_shaper_test.sv
// Self-checking bench for the gain shaper with a register shadow model.
// Assumes a short release step of 8 cycles set by parameter.
`timescale 1ns/100ps
`default_nettype none
module dgc_gain_shaper_test;
  logic              clk_sys;
  logic              rst = 1'b1;
  logic [15:0]       regAddr = 16'h0000;
  logic [15:0]       regWrData = 16'h0000;
  logic              regWrEn = 1'b0;
  logic              regRdEn = 1'b0;
  logic [15:0]       rdData;
  logic              rdValid;
  logic              sampleStrobe = 1'b0;
  logic [6:0]        levelIn = 7'h00;
  logic [7:0]        crestIn = 8'h00;
  logic signed [7:0] gain;
  logic              gateAct;
  logic              fastRel;
  int                mismatches = 0;
  int                n_checks = 0;
  int                mdl [4] = '{16'h0000, 16'h0133, 16'h0018, 16'h0000};
  int                msk [4] = '{16'h0100, 16'h01ff, 16'hffff, 16'h07ff};
  int                rel [3] = '{4, 8, 32};

  dgc_gain_shaper #(.REL_STEP_CYCLES(32'd8)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData_q(rdData), .regRdValid_q(rdValid), .sampleStrobe(sampleStrobe),
    .levelIn(levelIn), .crestIn(crestIn), .gainOut_q(gain), .gateActive_q(gateAct),
    .fastRelease_q(fastRel));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    if (a[15:2] == 14'h03a0)
      mdl[a[1:0]] = d & msk[a[1:0]];
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk({15'h0000, rdValid}, 16'h0001);
    chk(rdData, a[15:2] == 14'h03a0 ? 16'(mdl[a[1:0]]) : 16'h0000);
  endtask

  task automatic smp(input logic [6:0] l, input logic [7:0] c);
    @(posedge clk_sys);
    levelIn <= l;
    crestIn <= c;
    sampleStrobe <= 1'b1;
    @(posedge clk_sys);
    sampleStrobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // Counts the cycles between two successive gain steps.
  task automatic rate(input int exp);
    logic signed [7:0] g;
    int n;
    #1;
    repeat (2)
    begin
      g = gain;
      n = 0;
      while (gain === g && n < 600)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
    end
    chk(16'(n), 16'(exp));
  endtask

  // Expected gain in 0.75 dB units from the knee, both slopes and the limits.
  function automatic int model(input int l, k, o, hi, lo, lowc, upc);
    int g;
    int fl [5] = '{0, -16, -24, -32, -48};
    int cl [4] = '{16, 24, 32, 48};
    if (l < k)
      g = l - o + ((hi < 5) ? ((k - l) >> hi) : 0);
    else
      g = l - o - ((lo < 4) ? ((l - k) >> lo) : 0);
    if (g < fl[lowc])
      g = fl[lowc];
    if (g > cl[upc])
      g = cl[upc];
    return g;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end

  initial
  begin
    logic [15:0] a;
    int          kIn, kOut, hiC, loC, lowC, upC, lvl;
    void'($urandom(32'hee30));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(16'h0e80 + 16'(i));
    repeat (24)
    begin
      a = 16'h0e80 + 16'($urandom_range(4));
      wr(a, 16'($urandom));
      rd(a);
    end
    for (int t = 0; t < 4; t++)
    begin
      wr(16'h0e82, 16'(t << 8));
      smp(7'h00, 8'(15 + 8 * t));
      chk({15'h0000, fastRel}, 16'h0000);
      smp(7'h00, 8'(16 + 8 * t));
      chk({15'h0000, fastRel}, 16'h0001);
    end
    wr(16'h0e81, 16'h0013);
    wr(16'h0e83, 16'h0000);
    wr(16'h0e80, 16'h0000);
    wr(16'h0e82, 16'h0c00);
    smp(7'h7f, 8'h00);
    chk({15'h0000, gateAct}, 16'h0000);
    smp(7'h00, 8'h00);
    for (int k = 0; k < 600 && gain !== 8'sh00; k++)
      @(posedge clk_sys);
    wr(16'h0e80, 16'h0100);
    for (int c = 6; c >= 0; c--)
    begin
      wr(16'h0e82, 16'(c << 12) | 16'h0c00);
      smp(7'h7f, 8'h00);
      chk({15'h0000, gateAct}, 16'h0001);
      chk(16'(gain), 16'(-48 + 8 * c));
    end
    wr(16'h0e80, 16'h0000);
    smp(7'h00, 8'h00);
    rate(8);
    wr(16'h0e81, 16'h0053);
    rate(32);
    smp(7'h00, 8'h28);
    for (int q = 0; q < 3; q++)
    begin
      wr(16'h0e82, 16'(q << 6));
      rate(rel[q]);
    end
    for (int j = 0; j < 6; j++)
    begin
      kIn = $urandom_range(60);
      kOut = $urandom_range(30);
      hiC = $urandom_range(5);
      loC = $urandom_range(4);
      lowC = $urandom_range(4);
      upC = $urandom_range(3);
      lvl = $urandom_range(127);
      wr(16'h0e81, 16'((lowC << 2) | upC));
      wr(16'h0e82, 16'((hiC << 3) | loC));
      wr(16'h0e83, 16'((kIn << 5) | kOut));
      smp(7'(lvl), 8'h00);
      repeat (850) @(posedge clk_sys);
      #1;
      chk(16'(gain), 16'(model(lvl, kIn, kOut, hiC, loC, lowC, upC)));
    end
    test_done();
  end
endmodule // dgc_gain_shaper_test
`default_nettype wire
